/* File: dv/sxb_slave_model.sv */
// Behavioural slave behind one crossbar slave port.
// Assumes registered one-cycle request pulses and a single clock.
`timescale 1ns/1ps
module sxb_slave_model #(
   parameter int DELAY = 0
) (
   input  wire logic                 core_clk,
   input  wire logic                 sys_rst,
   input  wire sxb_pkg::sxb_req_type req,
   output sxb_pkg::sxb_rsp_type      rsp
);
   logic [31:0] data;
   logic        busy;
   int          cnt;

   // Reads return the address, writes echo the data; idle data toggles
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         busy <= 1'b0;
         cnt  <= 0;
         rsp  <= '0;
      end else begin
         rsp.valid <= 1'b0;
         rsp.error <= 1'b0;
         rsp.rdata <= ~rsp.rdata;
         if (req.valid) begin
            busy <= 1'b1;
            cnt  <= DELAY;
            data <= req.write ? req.wdata : req.addr;
         end else if (busy) begin
            if (cnt == 0) begin
               busy      <= 1'b0;
               rsp.valid <= 1'b1;
               rsp.rdata <= data;
            end else begin
               cnt <= cnt - 1;
            end
         end
      end
   end
endmodule

/* File: dv/tb_top.sv */
// Self-checking bench for the system crossbar.
// Assumes the slave models answer every request they are given.
`timescale 1ns/1ps
module tb_top;
   logic                 core_clk, sys_rst;
   logic [1:0]           bootPins;
   sxb_pkg::sxb_req_type cpuReq, dmaReq, flashReq, sramReq, apbReq, gpioReq, seen;
   sxb_pkg::sxb_rsp_type cpuRsp, dmaRsp, flashRsp, sramRsp, apbRsp, gpioRsp, rsp;
   logic                 cpuReady, dmaReady, flashOptSel, flashSysSel;
   logic                 gateSetValid;
   logic [7:0]           gateSetValue, periphClkEn;
   logic [5:0]           hit;
   int                   error_cnt, cmp_count;

   system_crossbar uut (.core_clk(core_clk), .sys_rst(sys_rst), .bootPins(bootPins),
      .cpuReq(cpuReq), .dmaReq(dmaReq), .cpuRsp(cpuRsp), .dmaRsp(dmaRsp),
      .cpuReady(cpuReady), .dmaReady(dmaReady), .flashReq(flashReq),
      .flashOptSel(flashOptSel), .flashSysSel(flashSysSel), .flashRsp(flashRsp),
      .sramReq(sramReq), .sramRsp(sramRsp), .apbReq(apbReq), .apbRsp(apbRsp),
      .gpioReq(gpioReq), .gpioRsp(gpioRsp), .gateSetValid(gateSetValid),
      .gateSetValue(gateSetValue), .periphClkEn(periphClkEn));
   sxb_slave_model #(.DELAY(2)) flashM (.core_clk(core_clk), .sys_rst(sys_rst), .req(flashReq), .rsp(flashRsp));
   sxb_slave_model sramM (.core_clk(core_clk), .sys_rst(sys_rst), .req(sramReq), .rsp(sramRsp));
   sxb_slave_model #(.DELAY(3)) apbM (.core_clk(core_clk), .sys_rst(sys_rst), .req(apbReq), .rsp(apbRsp));
   sxb_slave_model #(.DELAY(1)) gpioM (.core_clk(core_clk), .sys_rst(sys_rst), .req(gpioReq), .rsp(gpioRsp));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   // Records which slave port a request reached: {sys, opt, gpio, apb, sram, flash}
   always @(posedge core_clk) begin
      if (flashReq.valid) begin
         hit[0]  <= 1'b1;
         hit[4]  <= flashOptSel;
         hit[5]  <= flashSysSel;
         seen    <= flashReq;
      end
      if (sramReq.valid) begin
         hit[1] <= 1'b1;
         seen   <= sramReq;
      end
      if (apbReq.valid) begin
         hit[2] <= 1'b1;
         seen   <= apbReq;
      end
      if (gpioReq.valid) begin
         hit[3] <= 1'b1;
         seen   <= gpioReq;
      end
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic summarize;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rst(input logic [1:0] boot);
      @(posedge core_clk);
      #1;
      sys_rst  = 1'b1;
      bootPins = boot;
      repeat (8) @(posedge core_clk);
      #1;
      sys_rst = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      bootPins = ~boot;
   endtask

   task automatic xfer(input bit m, input logic w, input logic [1:0] sz, input logic [31:0] a, input logic [31:0] d);
      sxb_pkg::sxb_req_type r;
      int n;
      r = '{1'b1, w, sz, a, d};
      @(posedge core_clk);
      #1;
      hit = '0;
      if (m) dmaReq = r;
      else cpuReq = r;
      n = 0;
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while ((m ? dmaReady : cpuReady) !== 1'b1 && n < 50);
      if (n >= 50) begin
         error_cnt++;
         summarize();
      end
      rsp = m ? dmaRsp : cpuRsp;
      r.valid = 1'b0;
      if (m) dmaReq = r;
      else cpuReq = r;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_map;
      logic [31:0] a [17] = '{32'h0800_0000, 32'h0800_7ffc, 32'h0800_8000, 32'h2000_0000, 32'h2000_0fff,
         32'h2000_1000, 32'h1fff_ec00, 32'h1fff_ebfc, 32'h1fff_f800, 32'h1fff_fbfc, 32'h1fff_fc00,
         32'h4000_0000, 32'h4801_0000, 32'h4800_0000, 32'h4800_1800, 32'h0000_7ffc, 32'h6000_0000};
      logic [5:0] e [17] = '{6'h01, 6'h01, 6'h00, 6'h02, 6'h02, 6'h00, 6'h21, 6'h00, 6'h11, 6'h11,
         6'h00, 6'h04, 6'h00, 6'h08, 6'h00, 6'h01, 6'h00};
      for (int i = 0; i < 17; i++) begin
         xfer(i[0], 1'b0, sxb_pkg::SIZE_WORD, a[i], 32'h0);
         chk({26'h0, hit}, {26'h0, e[i]});
         chk({31'h0, rsp.error}, {31'h0, e[i] == 6'h00});
         if (e[i] != 6'h00) chk(rsp.rdata, a[i]);
      end
   endtask

   task automatic t_narrow;
      xfer(1'b0, 1'b1, sxb_pkg::SIZE_BYTE, 32'h4000_0005, 32'h0000_a500);
      chk(seen.wdata, 32'ha5a5_a5a5);
      chk({30'h0, seen.size}, {30'h0, sxb_pkg::SIZE_WORD});
      xfer(1'b1, 1'b1, sxb_pkg::SIZE_HALF, 32'h4001_0002, 32'h1234_0000);
      chk(seen.wdata, 32'h1234_1234);
      chk(rsp.rdata, 32'h1234_1234);
   endtask

   task automatic t_rr;
      int q[$];
      sxb_pkg::sxb_req_type r;
      r = '{1'b1, 1'b0, sxb_pkg::SIZE_WORD, sxb_pkg::SRAM_BASE, 32'h0};
      @(posedge core_clk);
      #1;
      cpuReq = r;
      r.addr = 32'h2000_0004;
      dmaReq = r;
      for (int n = 0; n < 60 && q.size() < 3; n++) begin
         @(posedge core_clk);
         #1;
         if (cpuReady === 1'b1) q.push_back(0);
         if (dmaReady === 1'b1) begin
            q.push_back(1);
            dmaReq.valid = 1'b0;
         end
      end
      cpuReq.valid = 1'b0;
      chk(q.size(), 3);
      if (q.size() == 3) begin
         chk(q[0], 0);
         chk(q[1], 1);
         chk(q[2], 0);
      end
   endtask

   task automatic t_gate;
      logic [7:0] v [3] = '{8'hf0, 8'h00, 8'h3c};
      logic [7:0] x [3] = '{8'hf3, 8'h03, 8'h3f};
      chk({24'h0, periphClkEn}, 32'h03);
      for (int i = 0; i < 3; i++) begin
         gateSetValid = 1'b1;
         gateSetValue = v[i];
         @(posedge core_clk);
         #1;
         gateSetValid = 1'b0;
         chk({24'h0, periphClkEn}, {24'h0, x[i]});
      end
      rst(2'h0);
      chk({24'h0, periphClkEn}, 32'h03);
   endtask

   task automatic t_boot;
      logic [1:0] b [3] = '{2'h3, 2'h1, 2'h2};
      logic [5:0] e [3] = '{6'h02, 6'h21, 6'h01};
      for (int i = 0; i < 3; i++) begin
         rst(b[i]);
         xfer(1'b0, 1'b0, sxb_pkg::SIZE_WORD, 32'h0000_0010, 32'h0);
         chk({26'h0, hit}, {26'h0, e[i]});
         chk(rsp.rdata, 32'h0000_0010);
      end
      rst(2'h0);
   endtask

   initial begin
      error_cnt    = 0;
      cmp_count    = 0;
      sys_rst      = 1'b1;
      bootPins     = 2'h0;
      cpuReq       = '0;
      dmaReq       = '0;
      gateSetValid = 1'b0;
      gateSetValue = 8'h00;
      hit          = '0;
      rst(2'h0);
      t_gate();
      t_map();
      t_narrow();
      t_rr();
      t_boot();
      summarize();
   end
endmodule

/* File: hdl/sxb_addr_decode.sv */
// Address decoder of the crossbar: maps a byte address to a slave target.
// Assumes the boot selection is already latched by the caller.
`timescale 1ns/1ps
module sxb_addr_decode #(
   parameter bit LARGE_VARIANT = 1'b0
) (
   input  wire logic [31:0]            addr,
   input  wire logic [1:0]             bootSel,
   output sxb_pkg::sxb_target_type     target
);

   function automatic logic inRange(input logic [31:0] a, input logic [31:0] base, input logic [31:0] size);
      inRange = (a >= base) && ((a - base) < size);
   endfunction

   logic [31:0] sramSize;
   logic [31:0] sysBase;
   logic [2:0]  region;

   assign sramSize = LARGE_VARIANT ? sxb_pkg::SRAM_SIZE_LRG : sxb_pkg::SRAM_SIZE_SML;
   assign sysBase  = LARGE_VARIANT ? sxb_pkg::SYS_BASE_LRG : sxb_pkg::SYS_BASE_SML;
   assign region   = addr[sxb_pkg::REGION_MSB:sxb_pkg::REGION_LSB];

   always_comb begin
      target = sxb_pkg::SLV_NONE;
      if (region == sxb_pkg::REGION_CODE) begin
         if (inRange(addr, sxb_pkg::ALIAS_BASE, sxb_pkg::ALIAS_SIZE)) begin
            case (bootSel)
               sxb_pkg::BOOT_SYSMEM: target = sxb_pkg::SLV_SYSMEM;
               sxb_pkg::BOOT_SRAM:   target = sxb_pkg::SLV_SRAM;
               default:              target = sxb_pkg::SLV_FLASH;
            endcase
         end else if (inRange(addr, sxb_pkg::FLASH_BASE, sxb_pkg::FLASH_SIZE)) begin
            target = sxb_pkg::SLV_FLASH;
         end else if (inRange(addr, sxb_pkg::OPT_BASE, sxb_pkg::OPT_SIZE)) begin
            target = sxb_pkg::SLV_OPT;
         end else if (addr >= sysBase && addr < sxb_pkg::SYS_END) begin
            target = sxb_pkg::SLV_SYSMEM;
         end
      end else if (region == sxb_pkg::REGION_SRAM) begin
         if (inRange(addr, sxb_pkg::SRAM_BASE, sramSize)) begin
            target = sxb_pkg::SLV_SRAM;
         end
      end else if (region == sxb_pkg::REGION_PERIPH) begin
         if (inRange(addr, sxb_pkg::APB_BASE, sxb_pkg::APB_SIZE) ||
             inRange(addr, sxb_pkg::AHB1_BASE, sxb_pkg::AHB1_SIZE)) begin
            target = sxb_pkg::SLV_APB;
         end else if (inRange(addr, sxb_pkg::GPIO_BASE, sxb_pkg::GPIO_SIZE)) begin
            target = sxb_pkg::SLV_GPIO;
         end
      end
   end

endmodule

/* File: hdl/sxb_rr_arbiter.sv */
// Two-requester round-robin arbiter with last-grant memory.
// Assumes synchronous active-high reset.
`timescale 1ns/1ps
module sxb_rr_arbiter (
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic [1:0] req,
   input  wire logic       advance,
   output logic      [1:0] grant
);

   typedef struct packed {
      logic lastDma;
   } sxb_arb_state_type;

   sxb_arb_state_type state_q;
   sxb_arb_state_type state_d;

   always_comb begin
      state_d = state_q;
      grant   = 2'h0;
      if (req == 2'h3) begin
         grant = state_q.lastDma ? 2'h1 : 2'h2;
      end else begin
         grant = req;
      end
      if (advance && grant != 2'h0) begin
         state_d.lastDma = grant[1];
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   alternate_rr_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (req == 2'h3 && advance) |=> (req != 2'h3) || (grant != $past(grant)))
      else $error("round robin did not alternate");

endmodule

/* File: hdl/system_crossbar.sv */
// Top of the system crossbar: two masters, four slave ports, decode, arbitration,
// APB width conversion and the peripheral clock gates.
// Assumes masters hold a request until ready and slaves answer each request after any number of cycles.
`timescale 1ns/1ps
module system_crossbar #(
   parameter bit LARGE_VARIANT = 1'b0
) (
   input  wire logic                   core_clk,
   input  wire logic                   sys_rst,
   input  wire logic [1:0]             bootPins,
   input  wire sxb_pkg::sxb_req_type   cpuReq,
   input  wire sxb_pkg::sxb_req_type   dmaReq,
   output sxb_pkg::sxb_rsp_type        cpuRsp,
   output sxb_pkg::sxb_rsp_type        dmaRsp,
   output logic                        cpuReady,
   output logic                        dmaReady,
   output sxb_pkg::sxb_req_type        flashReq,
   output logic                        flashOptSel,
   output logic                        flashSysSel,
   input  wire sxb_pkg::sxb_rsp_type   flashRsp,
   output sxb_pkg::sxb_req_type        sramReq,
   input  wire sxb_pkg::sxb_rsp_type   sramRsp,
   output sxb_pkg::sxb_req_type        apbReq,
   input  wire sxb_pkg::sxb_rsp_type   apbRsp,
   output sxb_pkg::sxb_req_type        gpioReq,
   input  wire sxb_pkg::sxb_rsp_type   gpioRsp,
   input  wire logic                   gateSetValid,
   input  wire logic [7:0]             gateSetValue,
   output logic [7:0]                  periphClkEn
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      logic                    bootLatched;
      logic [1:0]              bootSel;
      logic                    busy;
      logic                    ownerDma;
      sxb_pkg::sxb_target_type target;
      sxb_pkg::sxb_rsp_type    cpuRsp;
      sxb_pkg::sxb_rsp_type    dmaRsp;
      logic                    cpuReady;
      logic                    dmaReady;
      sxb_pkg::sxb_req_type    flashReq;
      logic                    flashOptSel;
      logic                    flashSysSel;
      sxb_pkg::sxb_req_type    sramReq;
      sxb_pkg::sxb_req_type    apbReq;
      sxb_pkg::sxb_req_type    gpioReq;
      logic [7:0]              clkEn;
   } sxb_top_state_type;

   sxb_top_state_type state_q;
   sxb_top_state_type state_d;

   // Narrow write data replicated across all four lanes
   function automatic logic [31:0] widenData(input logic [1:0] size, input logic [1:0] lane,
                                             input logic [31:0] data);
      logic [7:0]  b;
      logic [15:0] h;
      b = data[8*lane +: 8];
      h = lane[1] ? data[31:16] : data[15:0];
      case (size)
         sxb_pkg::SIZE_BYTE: widenData = {4{b}};
         sxb_pkg::SIZE_HALF: widenData = {2{h}};
         default:            widenData = data;
      endcase
   endfunction

   logic [1:0]              arbReq;
   logic [1:0]              grant;
   logic                    advance;
   sxb_pkg::sxb_req_type    selReq;
   sxb_pkg::sxb_target_type decTarget;
   sxb_pkg::sxb_rsp_type    slvRsp;
   logic [31:0]             laneData;

   assign arbReq  = {dmaReq.valid, cpuReq.valid};
   assign advance = !state_q.busy && state_q.bootLatched;
   assign selReq  = grant[1] ? dmaReq : cpuReq;
   assign laneData = selReq.wdata >> {selReq.addr[1:0], 3'h0};

   // -----------------------------------------------------------------
   // Arbitration and decode
   // -----------------------------------------------------------------
   sxb_rr_arbiter u_arb (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .req      (arbReq),
      .advance  (advance),
      .grant    (grant)
   );

   sxb_addr_decode #(
      .LARGE_VARIANT (LARGE_VARIANT)
   ) u_dec (
      .addr    (selReq.addr),
      .bootSel (state_q.bootSel),
      .target  (decTarget)
   );

   always_comb begin
      case (state_q.target)
         sxb_pkg::SLV_FLASH, sxb_pkg::SLV_OPT, sxb_pkg::SLV_SYSMEM: slvRsp = flashRsp;
         sxb_pkg::SLV_SRAM: slvRsp = sramRsp;
         sxb_pkg::SLV_APB:  slvRsp = apbRsp;
         sxb_pkg::SLV_GPIO: slvRsp = gpioRsp;
         default:           slvRsp = '0;
      endcase
   end

   // -----------------------------------------------------------------
   // Transfer control
   // -----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      state_d.cpuRsp   = '0;
      state_d.dmaRsp   = '0;
      state_d.cpuReady = 1'b0;
      state_d.dmaReady = 1'b0;
      state_d.flashReq.valid = 1'b0;
      state_d.sramReq.valid  = 1'b0;
      state_d.apbReq.valid   = 1'b0;
      state_d.gpioReq.valid  = 1'b0;
      if (!state_q.bootLatched) begin
         state_d.bootLatched = 1'b1;
         state_d.bootSel     = bootPins;
      end
      if (gateSetValid) begin
         state_d.clkEn = gateSetValue | sxb_pkg::CLK_GATE_RST;
      end
      if (advance && grant != 2'h0) begin
         state_d.ownerDma = grant[1];
         state_d.target   = decTarget;
         if (decTarget == sxb_pkg::SLV_NONE) begin
            // Reserved space: no slave selected, error returned next cycle
            if (grant[1]) begin
               state_d.dmaRsp   = '{valid: 1'b1, error: 1'b1, rdata: 32'h0000_0000};
               state_d.dmaReady = 1'b1;
            end else begin
               state_d.cpuRsp   = '{valid: 1'b1, error: 1'b1, rdata: 32'h0000_0000};
               state_d.cpuReady = 1'b1;
            end
         end else begin
            state_d.busy = 1'b1;
            case (decTarget)
               sxb_pkg::SLV_FLASH, sxb_pkg::SLV_OPT, sxb_pkg::SLV_SYSMEM: begin
                  state_d.flashReq    = selReq;
                  state_d.flashOptSel = (decTarget == sxb_pkg::SLV_OPT);
                  state_d.flashSysSel = (decTarget == sxb_pkg::SLV_SYSMEM);
               end
               sxb_pkg::SLV_SRAM: state_d.sramReq = selReq;
               sxb_pkg::SLV_APB: begin
                  state_d.apbReq       = selReq;
                  state_d.apbReq.size  = sxb_pkg::SIZE_WORD;
                  state_d.apbReq.wdata = widenData(selReq.size, selReq.addr[1:0], selReq.wdata);
               end
               sxb_pkg::SLV_GPIO: state_d.gpioReq = selReq;
               default: state_d.busy = 1'b0;
            endcase
         end
      end else if (state_q.busy && slvRsp.valid) begin
         state_d.busy = 1'b0;
         if (state_q.ownerDma) begin
            state_d.dmaRsp   = slvRsp;
            state_d.dmaReady = 1'b1;
         end else begin
            state_d.cpuRsp   = slvRsp;
            state_d.cpuReady = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_q       <= '0;
         state_q.clkEn <= sxb_pkg::CLK_GATE_RST;
      end else begin
         state_q <= state_d;
      end
   end

   assign cpuRsp      = state_q.cpuRsp;
   assign dmaRsp      = state_q.dmaRsp;
   assign cpuReady    = state_q.cpuReady;
   assign dmaReady    = state_q.dmaReady;
   assign flashReq    = state_q.flashReq;
   assign flashOptSel = state_q.flashOptSel;
   assign flashSysSel = state_q.flashSysSel;
   assign sramReq     = state_q.sramReq;
   assign apbReq      = state_q.apbReq;
   assign gpioReq     = state_q.gpioReq;
   assign periphClkEn = state_q.clkEn;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   reserved_error_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (advance && grant == 2'h1 && decTarget == sxb_pkg::SLV_NONE) |=>
         cpuRsp.error && cpuReady && !flashReq.valid && !sramReq.valid && !apbReq.valid && !gpioReq.valid)
      else $error("reserved access not refused");

   apb_widen_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      apbReq.valid |-> apbReq.size == sxb_pkg::SIZE_WORD &&
         ($past(selReq.size) != sxb_pkg::SIZE_BYTE || apbReq.wdata == {4{apbReq.wdata[7:0]}}))
      else $error("apb write not widened");

   gate_reset_a: assert property (@(posedge core_clk)
      $past(sys_rst) |-> periphClkEn == sxb_pkg::CLK_GATE_RST)
      else $error("clock gates wrong after reset");

   sram_route_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (advance && grant != 2'h0 && selReq.addr == 32'h2000_0fff) |=> sramReq.valid)
      else $error("sram top byte not routed");

   flash_route_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (advance && grant != 2'h0 && selReq.addr[31:15] == 17'h1000) |=> flashReq.valid && !flashOptSel)
      else $error("flash not routed");

   opt_route_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (advance && grant != 2'h0 && selReq.addr[31:10] == 22'h7fffe) |=> flashReq.valid && flashOptSel)
      else $error("option bytes not routed");

   gpio_route_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      gpioReq.valid |-> $past(selReq.addr[31:13]) == 19'h24000)
      else $error("gpio segment reached outside gpio space");

   one_owner_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      !(cpuReady && dmaReady))
      else $error("both masters answered together");

   reserved_dma_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (advance && grant == 2'h2 && decTarget == sxb_pkg::SLV_NONE) |=>
         dmaRsp.error && dmaReady && !flashReq.valid && !sramReq.valid && !apbReq.valid && !gpioReq.valid)
      else $error("reserved dma access not refused");

   region_reserved_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (advance && grant != 2'h0 && selReq.addr[31:29] != sxb_pkg::REGION_CODE &&
         selReq.addr[31:29] != sxb_pkg::REGION_SRAM && selReq.addr[31:29] != sxb_pkg::REGION_PERIPH) |=>
         (cpuReady && cpuRsp.error) || (dmaReady && dmaRsp.error))
      else $error("unused region not refused");

   sram_span_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (advance && grant != 2'h0 && selReq.addr == 32'h2000_1000) |=> sramReq.valid == LARGE_VARIANT)
      else $error("sram span edge wrong");

   sysmem_route_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (advance && grant != 2'h0 && selReq.addr[31:10] == 22'h7fffb) |=> flashReq.valid && flashSysSel)
      else $error("system memory not routed");

   alias_sram_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (advance && grant != 2'h0 && selReq.addr[31:15] == 17'h0000 && state_q.bootSel == sxb_pkg::BOOT_SRAM)
         |=> sramReq.valid)
      else $error("alias not routed to sram");

   alias_sysmem_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (advance && grant != 2'h0 && selReq.addr[31:15] == 17'h0000 && state_q.bootSel == sxb_pkg::BOOT_SYSMEM)
         |=> flashReq.valid && flashSysSel)
      else $error("alias not routed to system memory");

   apb_route_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (advance && grant != 2'h0 && selReq.addr[31:17] == 15'h2000) |=> apbReq.valid)
      else $error("apb peripheral not routed to bridge");

   half_widen_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (apbReq.valid && $past(selReq.size) == sxb_pkg::SIZE_HALF) |->
         apbReq.wdata == {2{apbReq.wdata[15:0]}} && apbReq.wdata[15:0] == $past(laneData[15:0]))
      else $error("apb half word not widened");

   byte_lane_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (apbReq.valid && $past(selReq.size) == sxb_pkg::SIZE_BYTE) |-> apbReq.wdata[7:0] == $past(laneData[7:0]))
      else $error("apb byte taken from wrong lane");

endmodule

/* File: inc/sxb_pkg.sv */
// Constants and carrier types for the system crossbar address decoder.
// Assumes one clock domain and synchronous, active-high reset.
// Summary of operation
// - When both masters request in the same cycle, grants alternate in round-robin order.
// - The crossbar has two master ports (processor, DMA) and four slave ports (flash, SRAM, APB segment, GPIO segment).
// - The GPIO segment serves only the GPIO port regions; every APB peripheral goes through the bridge segment.
// - The bridge path is fully synchronous to the single system clock.
// - Byte or half-word writes to APB registers become 32-bit writes with the data replicated on all lanes.
// - Multi-byte data is little endian, the lowest address holding the least significant byte.
// - The space is split into eight 512 MB regions selected by the top three address bits.
// - In the small variant, 0x2000_0000 to 0x2000_0FFF (4 KB) goes to SRAM.
// - 0x0800_0000 to 0x0800_7FFF (32 KB) goes to main flash through the flash slave.
// - 0x0000_0000 to 0x0000_7FFF aliases flash, system memory or SRAM per the boot choice caught at reset.
// - 0x1FFF_F800 to 0x1FFF_FBFF (1 KB) goes to the option byte area of the flash slave.
// - In the small variant, 0x1FFF_EC00 to 0x1FFF_F7FF (3 KB) is system memory.
// - In the large variant, SRAM spans to 0x2000_17FF (6 KB) and system memory starts at 0x1FFF_C400 (13 KB).
// - Every address not assigned to memory or a peripheral is reserved.
// - After reset all peripheral clock gates are off except SRAM and flash.
package sxb_pkg;

   localparam logic [31:0] FLASH_BASE    = 32'h0800_0000;
   localparam logic [31:0] FLASH_SIZE    = 32'h0000_8000;
   localparam logic [31:0] ALIAS_BASE    = 32'h0000_0000;
   localparam logic [31:0] ALIAS_SIZE    = 32'h0000_8000;
   localparam logic [31:0] OPT_BASE      = 32'h1fff_f800;
   localparam logic [31:0] OPT_SIZE      = 32'h0000_0400;
   localparam logic [31:0] SYS_END       = 32'h1fff_f800;
   localparam logic [31:0] SYS_BASE_SML  = 32'h1fff_ec00;
   localparam logic [31:0] SYS_BASE_LRG  = 32'h1fff_c400;
   localparam logic [31:0] SRAM_BASE     = 32'h2000_0000;
   localparam logic [31:0] SRAM_SIZE_SML = 32'h0000_1000;
   localparam logic [31:0] SRAM_SIZE_LRG = 32'h0000_1800;
   localparam logic [31:0] APB_BASE      = 32'h4000_0000;
   localparam logic [31:0] APB_SIZE      = 32'h0002_0000;
   localparam logic [31:0] AHB1_BASE     = 32'h4002_0000;
   localparam logic [31:0] AHB1_SIZE     = 32'h0000_4400;
   localparam logic [31:0] GPIO_BASE     = 32'h4800_0000;
   localparam logic [31:0] GPIO_SIZE     = 32'h0000_1800;
   localparam logic [2:0]  REGION_CODE   = 3'h0;
   localparam logic [2:0]  REGION_PERIPH = 3'h2;
   localparam logic [2:0]  REGION_SRAM   = 3'h1;
   localparam int          REGION_MSB    = 31;
   localparam int          REGION_LSB    = 29;
   localparam logic [1:0]  SIZE_BYTE     = 2'h0;
   localparam logic [1:0]  SIZE_HALF     = 2'h1;
   localparam logic [1:0]  SIZE_WORD     = 2'h2;
   localparam logic [1:0]  BOOT_FLASH    = 2'h0;
   localparam logic [1:0]  BOOT_SYSMEM   = 2'h1;
   localparam logic [1:0]  BOOT_SRAM     = 2'h3;
   localparam int          NUM_CLK_GATES = 8;
   localparam logic [7:0]  CLK_GATE_RST  = 8'h03;

   typedef enum logic [2:0] {
      SLV_NONE, SLV_FLASH, SLV_OPT, SLV_SYSMEM, SLV_SRAM, SLV_APB, SLV_GPIO
   } sxb_target_type;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [1:0]  size;
      logic [31:0] addr;
      logic [31:0] wdata;
   } sxb_req_type;

   typedef struct packed {
      logic        valid;
      logic        error;
      logic [31:0] rdata;
   } sxb_rsp_type;

endpackage
